// ==== core/cte_regs.sv ====
// Timer/watchdog and charge-enable control registers with their timers.
// Assumes the access port is already decoded from the serial bus, one cycle per access,
// and that the charger status inputs are synchronous to CORE_CLK except EN_PIN.
`timescale 1ns/1ps
`default_nettype none
module cte_regs #(
    parameter longint unsigned WDT_LIMIT = cte_pkg::WDT_CYCLES,
    parameter longint unsigned PRE_LIMIT = cte_pkg::PRE_CYCLES,
    parameter longint unsigned CHG_LIMIT = cte_pkg::CHG_CYCLES
) (
    input wire logic CORE_CLK,                // 50 MHz core clock
    input wire logic RESET_N,                 // Synchronous reset, active low
    input wire cte_pkg::cte_req_s REQ,        // Register access request
    output logic [7:0] RDATA,                 // Read data, valid cycle after rd
    output logic RVALID,                      // Read data strobe
    input wire cte_pkg::cte_chg_s CHG,        // Charger phase and battery state
    input wire logic EN_PIN,                  // Asynchronous enable pin
    output logic CHARGE_ON,                   // Charging allowed
    output logic MISSING_BATT_DET,            // Unconnected battery detection enable
    output logic PRE_TIMEOUT,                 // Pre-charge timer expired
    output logic CHG_TIMEOUT,                 // Charge timer expired
    output logic STB_WDT_TIMEOUT,             // Standby watchdog expired
    output logic OTG_WDT_TIMEOUT,             // OTG watchdog expired
    output logic CHG_WDT_TIMEOUT              // Charge watchdog expired
);
    import cte_pkg::*;

    // ********************************************************
    // Register state
    // ********************************************************
    logic [7:0] timer_ctrl, next_timer_ctrl;
    logic [7:0] enable_ctrl, next_enable_ctrl;
    logic [7:0] next_rdata;
    logic next_rvalid;
    logic clear_pulse, next_clear_pulse;
    logic wr_timer, wr_enable, wd_kick;

    assign wr_timer = REQ.wr && (REQ.addr == ADDR_TIMER_CTRL);
    assign wr_enable = REQ.wr && (REQ.addr == ADDR_ENABLE_CTRL);
    // Any register access by the host counts as servicing the watchdogs
    assign wd_kick = REQ.wr || REQ.rd;

    // Writes and reads; reserved bits masked off both ways
    always_comb begin
        next_timer_ctrl = timer_ctrl;
        next_enable_ctrl = enable_ctrl;
        next_clear_pulse = 1'b0;
        next_rdata = RDATA;
        next_rvalid = REQ.rd;
        if (wr_timer) begin
            next_timer_ctrl = REQ.wdata & TIMER_CTRL_MASK;
            next_clear_pulse = REQ.wdata[BIT_CLEAR];
        end
        // Pulse bit never stores, even in the cycle of the write that sets it
        next_timer_ctrl[BIT_CLEAR] = 1'b0;
        if (wr_enable) begin
            next_enable_ctrl = REQ.wdata & ENABLE_CTRL_MASK;
        end
        if (REQ.rd) begin
            case (REQ.addr)
                ADDR_TIMER_CTRL: next_rdata = timer_ctrl & TIMER_CTRL_MASK;
                ADDR_ENABLE_CTRL: next_rdata = enable_ctrl & ENABLE_CTRL_MASK;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            timer_ctrl <= TIMER_CTRL_RESET;
            enable_ctrl <= ENABLE_CTRL_RESET;
            clear_pulse <= 1'b0;
            RDATA <= 8'h00;
            RVALID <= 1'b0;
        end else begin
            timer_ctrl <= next_timer_ctrl;
            enable_ctrl <= next_enable_ctrl;
            clear_pulse <= next_clear_pulse;
            RDATA <= next_rdata;
            RVALID <= next_rvalid;
        end
    end

    // ********************************************************
    // Enable pin synchroniser
    // ********************************************************
    logic [2:0] pin_sync, next_pin_sync;
    logic pin_level, next_pin_level;

    // Level changes only once the second and third stages agree
    always_comb begin
        next_pin_sync = {pin_sync[1:0], EN_PIN};
        next_pin_level = pin_level;
        if (pin_sync[1] == pin_sync[2]) begin
            next_pin_level = pin_sync[2];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            pin_sync <= 3'b000;
            pin_level <= 1'b0;
        end else begin
            pin_sync <= next_pin_sync;
            pin_level <= next_pin_level;
        end
    end

    // ********************************************************
    // Charge decision
    // ********************************************************
    logic pin_enable, chg_enabled, next_charge_on;

    always_comb begin
        // Polarity bit one reads the pin active high
        pin_enable = enable_ctrl[BIT_POL] ? pin_level : !pin_level;
        // Register command is active low
        chg_enabled = enable_ctrl[BIT_SRC_SEL] ? !enable_ctrl[BIT_CMD]
                                               : pin_enable;
        if (chg_enabled) begin
            next_charge_on = 1'b1;
        end else if (enable_ctrl[BIT_AUTO]) begin
            next_charge_on = CHG.dead_batt;
        end else begin
            next_charge_on = 1'b0;
        end
        // Auto off and enabled still charges: only the disabled case differs
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            CHARGE_ON <= 1'b0;
            MISSING_BATT_DET <= 1'b1;
        end else begin
            CHARGE_ON <= next_charge_on;
            MISSING_BATT_DET <= enable_ctrl[BIT_MISS_DET];
        end
    end

    // ********************************************************
    // Safety timers and watchdogs
    // ********************************************************
    logic pre_count, chg_count, trickle_ok;
    logic pre_exp, chg_exp, stb_exp, otg_exp, cwd_exp;

    // Trickle phase halts both safety timers unless the run bit is set
    assign trickle_ok = !CHG.trickle || timer_ctrl[BIT_TRICKLE];
    assign pre_count = (CHG.precharge || CHG.trickle) && trickle_ok;
    assign chg_count = (CHG.fast || CHG.precharge || CHG.trickle) && trickle_ok;

    cte_timer #(.LIMIT(PRE_LIMIT)) u_pre (
        .CORE_CLK(CORE_CLK),
        .RESET_N(RESET_N),
        .enable(!timer_ctrl[BIT_PRE_DIS]),
        .count(pre_count),
        .clear(clear_pulse),
        .expired(pre_exp)
    );
    cte_timer #(.LIMIT(CHG_LIMIT)) u_chg (
        .CORE_CLK(CORE_CLK),
        .RESET_N(RESET_N),
        .enable(!timer_ctrl[BIT_CHG_DIS]),
        .count(chg_count),
        .clear(clear_pulse),
        .expired(chg_exp)
    );
    // Watchdogs restart on every host access; standby runs whenever armed, whatever the input power
    cte_timer #(.LIMIT(WDT_LIMIT)) u_stb (
        .CORE_CLK(CORE_CLK),
        .RESET_N(RESET_N),
        .enable(timer_ctrl[BIT_STB_WDT]),
        .count(1'b1),
        .clear(wd_kick),
        .expired(stb_exp)
    );
    cte_timer #(.LIMIT(WDT_LIMIT)) u_otg (
        .CORE_CLK(CORE_CLK),
        .RESET_N(RESET_N),
        .enable(timer_ctrl[BIT_OTG_WDT]),
        .count(1'b1),
        .clear(wd_kick),
        .expired(otg_exp)
    );
    cte_timer #(.LIMIT(WDT_LIMIT)) u_cwd (
        .CORE_CLK(CORE_CLK),
        .RESET_N(RESET_N),
        .enable(timer_ctrl[BIT_CHG_WDT]),
        .count(1'b1),
        .clear(wd_kick),
        .expired(cwd_exp)
    );

    // Expiry flags registered once more so outputs come from flops
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            PRE_TIMEOUT <= 1'b0;
            CHG_TIMEOUT <= 1'b0;
            STB_WDT_TIMEOUT <= 1'b0;
            OTG_WDT_TIMEOUT <= 1'b0;
            CHG_WDT_TIMEOUT <= 1'b0;
        end else begin
            PRE_TIMEOUT <= pre_exp;
            CHG_TIMEOUT <= chg_exp;
            STB_WDT_TIMEOUT <= stb_exp;
            OTG_WDT_TIMEOUT <= otg_exp;
            CHG_WDT_TIMEOUT <= cwd_exp;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    property p_clear;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        wr_timer && REQ.wdata[BIT_CLEAR] |=> clear_pulse ##1 (!pre_exp && !chg_exp);
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not drop timers");

    property p_self_clear;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        wr_timer |=> !timer_ctrl[BIT_CLEAR];
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("clear bit stuck");

    property p_reserved;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        RVALID |-> (RDATA[7] == 1'b0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit read one");

    property p_stb_off;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        !timer_ctrl[BIT_STB_WDT] |=> !stb_exp;
    endproperty
    a_stb_off: assert property (p_stb_off) else $error("standby watchdog unarmed");

    property p_wdt_off;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        !timer_ctrl[BIT_OTG_WDT] && !timer_ctrl[BIT_CHG_WDT] |=> !otg_exp && !cwd_exp;
    endproperty
    a_wdt_off: assert property (p_wdt_off) else $error("watchdog expired unarmed");

    property p_pre_dis;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        timer_ctrl[BIT_PRE_DIS] |=> !pre_exp ##1 !PRE_TIMEOUT;
    endproperty
    a_pre_dis: assert property (p_pre_dis) else $error("pre-charge timer disabled");

    property p_chg_dis;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        timer_ctrl[BIT_CHG_DIS] |=> !chg_exp;
    endproperty
    a_chg_dis: assert property (p_chg_dis) else $error("charge timer disabled");

    property p_auto_off;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        !enable_ctrl[BIT_AUTO] && !chg_enabled |=> !CHARGE_ON;
    endproperty
    a_auto_off: assert property (p_auto_off) else $error("charged while off");

    property p_cmd;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        enable_ctrl[BIT_SRC_SEL] && !enable_ctrl[BIT_CMD] |=> CHARGE_ON;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command enable ignored");
endmodule
`default_nettype wire

// ==== core/cte_pkg.sv ====
// Constants, field layouts and carriers for the charger timer/enable control registers.
// Assumes a register access port driven by the device's serial-interface decoder.
// Operation
// - Timer clear pulse clears both timers, status
// - Standby watchdog bit arms 42 s watchdog
// - OTG and charge watchdog bits arm watchdogs
// - Pre-charge 36 min timer runs unless disabled
// - Charge 240 min timer runs unless disabled
// - Trickle bit lets timers count in trickle
// - Auto off: no charging while disabled
// - Auto on, disabled: charge only dead battery
// - Auto on, enabled: charge regardless of voltage
// - Source select: pin or register command
// - Register command zero enables, resets to one
// - Pin polarity: zero active low, one high
package cte_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [7:0] ADDR_TIMER_CTRL = 8'h10;
    localparam logic [7:0] ADDR_ENABLE_CTRL = 8'h11;

    // Writable masks; reserved bits are zero in these
    localparam logic [7:0] TIMER_CTRL_MASK = 8'h7F;
    localparam logic [7:0] ENABLE_CTRL_MASK = 8'h1F;
    localparam logic [7:0] TIMER_CTRL_RESET = 8'h01;
    localparam logic [7:0] ENABLE_CTRL_RESET = 8'h1B;

    // Field positions, register 0x10
    localparam int unsigned BIT_CLEAR = 6;
    localparam int unsigned BIT_STB_WDT = 5;
    localparam int unsigned BIT_OTG_WDT = 4;
    localparam int unsigned BIT_CHG_WDT = 3;
    localparam int unsigned BIT_PRE_DIS = 2;
    localparam int unsigned BIT_CHG_DIS = 1;
    localparam int unsigned BIT_TRICKLE = 0;
    // Field positions, register 0x11
    localparam int unsigned BIT_MISS_DET = 4;
    localparam int unsigned BIT_AUTO = 3;
    localparam int unsigned BIT_SRC_SEL = 2;
    localparam int unsigned BIT_CMD = 1;
    localparam int unsigned BIT_POL = 0;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam longint unsigned CLK_HZ = 50_000_000;
    localparam longint unsigned WDT_SEC = 42;
    localparam longint unsigned PRE_MIN = 36;
    localparam longint unsigned CHG_MIN = 240;
    localparam longint unsigned WDT_CYCLES = WDT_SEC * CLK_HZ;
    localparam longint unsigned PRE_CYCLES = PRE_MIN * 64'd60 * CLK_HZ;
    localparam longint unsigned CHG_CYCLES = CHG_MIN * 64'd60 * CLK_HZ;
    localparam int unsigned CNT_W = 40;

    // ********************************************************
    // Carriers
    // ********************************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cte_req_s;

    typedef struct packed {
        logic trickle;      // Charger is in trickle phase
        logic precharge;    // Charger is in pre-charge phase
        logic fast;         // Charger is in fast-charge phase
        logic dead_batt;    // Battery below dead-battery threshold
        logic otg_mode;     // OTG output active
        logic input_power;  // Input supply present
    } cte_chg_s;

    typedef enum logic [1:0] {
        CTE_TMR_IDLE = 2'b00,
        CTE_TMR_RUN = 2'b01,
        CTE_TMR_HOLD = 2'b10,
        CTE_TMR_EXPIRED = 2'b11
    } cte_tmr_e;

endpackage

// ==== core/cte_timer.sv ====
// One safety or watchdog timer with run, hold, clear and expiry.
// Assumes run and hold are registered levels on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cte_timer #(
    parameter longint unsigned LIMIT = 64'd100
) (
    input wire logic CORE_CLK,        // Core clock
    input wire logic RESET_N,         // Synchronous reset
    input wire logic enable,          // Timer armed
    input wire logic count,           // Count this cycle
    input wire logic clear,           // Restart count, drop expiry
    output logic expired              // Sticky expiry
);
    import cte_pkg::*;

    logic [CNT_W-1:0] cnt, next_cnt;
    logic next_expired;
    localparam logic [CNT_W-1:0] LIM = LIMIT[CNT_W-1:0];

    // Disarm or clear restarts; expiry holds until cleared or disarmed
    always_comb begin
        next_cnt = cnt;
        next_expired = expired;
        if (clear || !enable) begin
            next_cnt = '0;
            next_expired = 1'b0;
        end else if (count && !expired) begin
            if (cnt >= LIM - 1'b1) begin
                next_expired = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            cnt <= '0;
            expired <= 1'b0;
        end else begin
            cnt <= next_cnt;
            expired <= next_expired;
        end
    end

    property p_clear_drops;
        @(posedge CORE_CLK) disable iff (!RESET_N)
        clear |=> !expired;
    endproperty
    a_clear_drops: assert property (p_clear_drops) else $error("expiry survived a clear");
endmodule
`default_nettype wire

// ==== dv/cte_host.sv ====
// Host model: drives the decoded register access port of the control registers.
// Assumes read data and its strobe answer one cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module cte_host (
    input wire logic CORE_CLK,     // Core clock
    output var cte_pkg::cte_req_s REQ, // Register access request
    input wire logic [7:0] RDATA,  // Read data
    input wire logic RVALID        // Read data strobe
);
    import cte_pkg::*;

    // ****************
    // Access tasks
    // ****************
    // Idle address is inverted after each access, and idle data after each write, so a stale value never looks like a request
    initial begin
        REQ = '0;
    end

    // One-cycle write strobe, launched and released on falling edges
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge CORE_CLK);
        REQ = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(negedge CORE_CLK);
        REQ = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    // Read answer is taken half a cycle after the edge that registered it
    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(negedge CORE_CLK);
        REQ = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: ~REQ.wdata};
        @(negedge CORE_CLK);
        REQ = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: REQ.wdata};
        ok = RVALID;
        data = RDATA;
    endtask

    // Host arms all watchdogs while it configures, so a hung host cannot leave it stuck
    task automatic arm_watchdogs(input logic [7:0] base);
        wr(ADDR_TIMER_CTRL, base | 8'h38);
    endtask
endmodule
`default_nettype wire

// ==== dv/charger_timer_enable_ctrl_test.sv ====
// Self-checking bench for the timer/watchdog and charge-enable control registers.
// Assumes small timer limits so every expiry is seen within a short run.
`timescale 1ns/1ps
`default_nettype none
module charger_timer_enable_ctrl_test;
    import cte_pkg::*;

    typedef struct packed {
        logic [7:0] val;
        logic pin;
        logic dead;
        logic on;
    } cte_row_s;

    // ****************
    // Signals and instances
    // ****************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic en_pin = 1'b0;
    cte_chg_s chg = '0;
    cte_req_s req;
    logic [7:0] rdata;
    logic rvalid, charge_on, miss_det, pre_to, chg_to, stb_to, otg_to, cwd_to;
    int bad_count = 0;
    int checks = 0;
    // Enable register value, pin, dead battery, expected charge decision
    cte_row_s rows [11] = '{
        '{8'h1B, 1'b1, 1'b0, 1'b1}, '{8'h1B, 1'b0, 1'b0, 1'b0}, '{8'h1B, 1'b0, 1'b1, 1'b1},
        '{8'h0A, 1'b0, 1'b0, 1'b1}, '{8'h0A, 1'b1, 1'b0, 1'b0}, '{8'h02, 1'b1, 1'b1, 1'b0},
        '{8'h06, 1'b1, 1'b1, 1'b0}, '{8'h04, 1'b0, 1'b0, 1'b1}, '{8'h0C, 1'b1, 1'b0, 1'b1},
        '{8'h0E, 1'b1, 1'b1, 1'b1}, '{8'hEE, 1'b1, 1'b0, 1'b0}};

    // Free-running 50 MHz clock
    always #10 clk = ~clk;

    cte_regs #(.WDT_LIMIT(64'd30), .PRE_LIMIT(64'd20), .CHG_LIMIT(64'd40)) cte_regs_i (
        .CORE_CLK(clk), .RESET_N(rst_n), .REQ(req), .RDATA(rdata), .RVALID(rvalid),
        .CHG(chg), .EN_PIN(en_pin), .CHARGE_ON(charge_on), .MISSING_BATT_DET(miss_det),
        .PRE_TIMEOUT(pre_to), .CHG_TIMEOUT(chg_to), .STB_WDT_TIMEOUT(stb_to),
        .OTG_WDT_TIMEOUT(otg_to), .CHG_WDT_TIMEOUT(cwd_to));
    cte_host cte_host_i (.CORE_CLK(clk), .REQ(req), .RDATA(rdata), .RVALID(rvalid));

    // ****************
    // Helpers
    // ****************
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] data;
        logic ok;
        cte_host_i.rd(addr, data, ok);
        chk("read strobe", {7'b0, ok}, 8'h01);
        chk("read data", data, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Timeout flags packed as standby, OTG, charge watchdog, pre-charge, charge
    function automatic logic [7:0] tmo();
        return {3'b000, stb_to, otg_to, cwd_to, pre_to, chg_to};
    endfunction

    task automatic end_sim();
        if (bad_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard, well beyond the roughly 470 cycles the tests need
    initial begin
        #200_000;
        bad_count++;
        end_sim();
    end

    // ****************
    // Main sequence
    // ****************
    initial begin
        cyc(6);
        rst_n = 1'b1;
        cyc(5); // Pin synchroniser settles before the decision is judged
        chk("charge on", {7'b0, charge_on}, 8'h00);
        chk("miss det", {7'b0, miss_det}, 8'h01);
        chk("timeouts", tmo(), 8'h00);
        rd_chk(ADDR_TIMER_CTRL, 8'h01);
        rd_chk(ADDR_ENABLE_CTRL, 8'h1B);
        // Enable source, polarity and automatic mode combinations, except pin active high with auto off
        foreach (rows[i]) begin
            chg.dead_batt = rows[i].dead;
            en_pin = rows[i].pin;
            cte_host_i.wr(ADDR_ENABLE_CTRL, rows[i].val);
            rd_chk(ADDR_ENABLE_CTRL, rows[i].val & 8'h1F);
            cyc(5);
            chk("charge on", {7'b0, charge_on}, {7'b0, rows[i].on});
            chk("miss det", {7'b0, miss_det}, {7'b0, rows[i].val[4]});
        end
        // Unmapped address and reserved bits
        cte_host_i.wr(8'h12, 8'hAA);
        rd_chk(8'h12, 8'h00);
        rd_chk(ADDR_TIMER_CTRL, 8'h01);
        cte_host_i.wr(ADDR_TIMER_CTRL, 8'hFF);
        rd_chk(ADDR_TIMER_CTRL, 8'h3F);
        // Safety timers in pre-charge, then cleared by the pulse
        chg = '0;
        chg.precharge = 1'b1;
        cte_host_i.wr(ADDR_TIMER_CTRL, 8'h41);
        cyc(14);
        chk("timeouts", tmo(), 8'h00);
        cyc(12);
        chk("timeouts", tmo(), 8'h02);
        cyc(20);
        chk("timeouts", tmo(), 8'h03);
        cte_host_i.wr(ADDR_TIMER_CTRL, 8'h41);
        cyc(2);
        chk("timeouts", tmo(), 8'h00);
        rd_chk(ADDR_TIMER_CTRL, 8'h01);
        cte_host_i.wr(ADDR_TIMER_CTRL, 8'h07);
        cyc(50);
        chk("timeouts", tmo(), 8'h00);
        // Trickle phase: halted, then counting
        chg = '0;
        chg.trickle = 1'b1;
        cte_host_i.wr(ADDR_TIMER_CTRL, 8'h40);
        cyc(50);
        chk("timeouts", tmo(), 8'h00);
        cte_host_i.wr(ADDR_TIMER_CTRL, 8'h01);
        cyc(46);
        chk("timeouts", tmo(), 8'h03);
        // Watchdogs expire, restart on access, stay quiet once disarmed
        chg = '0;
        cte_host_i.wr(ADDR_TIMER_CTRL, 8'h41);
        cte_host_i.arm_watchdogs(8'h01);
        cyc(24);
        chk("timeouts", tmo(), 8'h00);
        cyc(12);
        chk("timeouts", tmo(), 8'h1C);
        rd_chk(ADDR_TIMER_CTRL, 8'h39);
        cyc(2);
        chk("timeouts", tmo(), 8'h00);
        cte_host_i.wr(ADDR_TIMER_CTRL, 8'h01);
        cyc(40);
        chk("timeouts", tmo(), 8'h00);
        // Fast phase runs only the charge timer
        chg.fast = 1'b1;
        cte_host_i.wr(ADDR_TIMER_CTRL, 8'h41);
        cyc(46);
        chk("timeouts", tmo(), 8'h01);
        // Mid-run reset returns registers and outputs to their reset state
        chg = '0;
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        cyc(1);
        chk("miss det", {7'b0, miss_det}, 8'h01);
        chk("timeouts", tmo(), 8'h00);
        rd_chk(ADDR_TIMER_CTRL, 8'h01);
        rd_chk(ADDR_ENABLE_CTRL, 8'h1B);
        end_sim();
    end
endmodule
`default_nettype wire
